/* shared/adc_out_defines.svh */
// Constants for the converter output path and mode selection.
// Assumes inclusion by bare name from design files.
`ifndef ADC_OUT_DEFINES_SVH
`define ADC_OUT_DEFINES_SVH

`define DATA_WIDTH          10
`define PIPE_LATENCY        5
`define DATA_RESET          10'h000
`define MSB_POS             9
`define DLL_RELOCK_CYCLES   100
`define MODE_RESET          2'h0

`endif

/* shared/adc_out_pkg.sv */
// Types for the converter output path and mode selection.
// Assumes nothing beyond a SystemVerilog compiler.
package adc_out_pkg;

	// Four levels of the mode input, quantised by the analog comparator
	typedef enum logic [1:0]
	{
		MODE_GROUND_LEVEL,
		MODE_ONE_THIRD,
		MODE_TWO_THIRDS,
		MODE_FULL_SUPPLY
	} mode_level_e;

	typedef enum logic
	{
		CODING_OFFSET_BINARY,
		CODING_TWOS_COMPLEMENT
	} coding_e;

endpackage : adc_out_pkg

/* rtl/adc_pipe_delay.sv */
// Fixed-length register delay line for converted words.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
`include "adc_out_defines.svh"

module adc_pipe_delay #(
	parameter int WIDTH  = `DATA_WIDTH,
	parameter int STAGES = `PIPE_LATENCY
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Data
	input  wire logic [WIDTH-1:0] dataIn,
	output logic      [WIDTH-1:0] dataOut
);

	// One process owns the whole line; STAGES must be at least two
	logic [STAGES-1:0][WIDTH-1:0] stage_reg;
	logic [STAGES-1:0][WIDTH-1:0] stage_next;

	always_comb
	begin
		if (!rst_n)
			stage_next = '0;
		else
			stage_next = {stage_reg[STAGES-2:0], dataIn};
	end

	always_ff @(posedge clk)
	begin
		stage_reg <= stage_next;
	end

	assign dataOut = stage_reg[STAGES-1];

endmodule : adc_pipe_delay

/* rtl/adc_output_pipeline_mode_select.sv */
// Output pipeline and operating-mode decode of a 10-bit sampling converter.
// Assumes the sample clock is clk, the core word is valid at each rising edge,
// and the four-level mode pin arrives already quantised by a comparator.
`timescale 1ns/1ps
`include "adc_out_defines.svh"

module adc_output_pipeline_mode_select #(
	parameter int WIDTH   = `DATA_WIDTH,
	parameter int LATENCY = `PIPE_LATENCY
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Converter core
	input  wire logic [WIDTH-1:0] sampleIn,
	// Mode pin, quantised level; modeConnected low models a floating pin
	input  wire logic [1:0]       modeLevel,
	input  wire logic             modeConnected,
	// Capture side
	output logic      [WIDTH-1:0] dataOut,
	output logic                  twosComplement,
	output logic                  dutyCycleStabilizer
);

	// Data path
	logic [WIDTH-1:0]         delayed;
	logic [WIDTH-1:0]         recoded;
	logic [WIDTH-1:0]         data_reg;
	logic [WIDTH-1:0]         data_next;

	// Mode decode
	logic                     twos_reg;
	logic                     twos_next;
	logic                     dcs_reg;
	logic                     dcs_next;
	logic [1:0]               effLevel;
	adc_out_pkg::mode_level_e level;
	adc_out_pkg::coding_e     coding;
	logic                     stabilizer;

	// Output coding chosen by one quantised level
	function automatic adc_out_pkg::coding_e level_coding(
		input adc_out_pkg::mode_level_e lvl
	);
		unique case (lvl)
			adc_out_pkg::MODE_FULL_SUPPLY:
			begin
				level_coding = adc_out_pkg::CODING_TWOS_COMPLEMENT;
			end
			adc_out_pkg::MODE_TWO_THIRDS:
			begin
				level_coding = adc_out_pkg::CODING_TWOS_COMPLEMENT;
			end
			adc_out_pkg::MODE_ONE_THIRD:
			begin
				level_coding = adc_out_pkg::CODING_OFFSET_BINARY;
			end
			adc_out_pkg::MODE_GROUND_LEVEL:
			begin
				level_coding = adc_out_pkg::CODING_OFFSET_BINARY;
			end
		endcase
	endfunction : level_coding

	// Stabilizer state chosen by one quantised level
	function automatic logic level_stabilizer(
		input adc_out_pkg::mode_level_e lvl
	);
		unique case (lvl)
			adc_out_pkg::MODE_FULL_SUPPLY:
			begin
				level_stabilizer = 1'b0;
			end
			adc_out_pkg::MODE_TWO_THIRDS:
			begin
				level_stabilizer = 1'b1;
			end
			adc_out_pkg::MODE_ONE_THIRD:
			begin
				level_stabilizer = 1'b1;
			end
			adc_out_pkg::MODE_GROUND_LEVEL:
			begin
				level_stabilizer = 1'b0;
			end
		endcase
	endfunction : level_stabilizer

	// Which bit lanes the coding touches
	function automatic logic lane_flips(
		input int lane
	);
		lane_flips = (lane == `MSB_POS);
	endfunction : lane_flips

	// Latency split: LATENCY delay stages, then the output register.
	// The sampling edge loads stage zero, so the word shows after
	// the LATENCY-th edge following it.
	adc_pipe_delay #(
		.WIDTH  (WIDTH),
		.STAGES (LATENCY)
	) uDelay (
		.clk     (clk),
		.rst_n   (rst_n),
		.dataIn  (sampleIn),
		.dataOut (delayed)
	);

	// Internal pull-down: floating pin reads as ground level
	assign effLevel   = modeConnected ? modeLevel : `MODE_RESET;
	assign level      = adc_out_pkg::mode_level_e'(effLevel);
	assign coding     = level_coding(level);
	assign stabilizer = level_stabilizer(level);

	// Pin is meant to be static; a change still takes effect next edge
	always_comb
	begin
		if (!rst_n)
		begin
			twos_next = 1'b0;
			dcs_next  = 1'b0;
		end
		else
		begin
			twos_next = (coding == adc_out_pkg::CODING_TWOS_COMPLEMENT);
			dcs_next  = stabilizer;
		end
	end

	always_ff @(posedge clk)
	begin
		twos_reg <= twos_next;
		dcs_reg  <= dcs_next;
	end

	// Twos complement is offset binary with only the top lane inverted
	genvar lane;
	generate
		for (lane = 0; lane < WIDTH; lane++)
		begin : gRecode
			if (lane_flips(lane))
			begin : gFlip
				assign recoded[lane] = delayed[lane] ^ twos_reg;
			end
			else
			begin : gPass
				assign recoded[lane] = delayed[lane];
			end
		end
	endgenerate

	// Coding applied at the last stage so a mode change shows on the next word
	always_comb
	begin
		if (!rst_n)
			data_next = WIDTH'(`DATA_RESET);
		else
			data_next = recoded;
	end

	// dataOut moves only here, after a rising edge; the mode flags move in the register block above
	always_ff @(posedge clk)
	begin
		data_reg <= data_next;
	end

	assign dataOut             = data_reg;
	assign twosComplement      = twos_reg;
	assign dutyCycleStabilizer = dcs_reg;

endmodule : adc_output_pipeline_mode_select

/* testbench/adc_capture_model.sv */
// Far-side capture logic for the output words.
// Assumes outputs settle well within 20 ns of the rising edge.
`timescale 1ns/1ps
`include "adc_out_defines.svh"
module adc_capture_model (
	// Capture port
	input  wire logic       clk,
	input  wire logic [9:0] dataOut,
	input  wire logic       stabilizerOn,
	output logic      [9:0] captured,
	output logic            relocked
);
	int lockCount = 0;
	always @(posedge clk) #20 captured = dataOut;
	// relocked rises once the stabilizer has stayed on for DLL_RELOCK_CYCLES edges; words are captured at every edge regardless
	always @(posedge clk)
		lockCount <= !stabilizerOn ? 0 : lockCount + int'(lockCount < `DLL_RELOCK_CYCLES);
	assign relocked = lockCount >= `DLL_RELOCK_CYCLES;
endmodule : adc_capture_model

/* testbench/adc_output_pipeline_mode_select_properties.sv */
// Checker for the output pipeline and mode decode.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
module adc_output_pipeline_mode_select_properties #(parameter int LATENCY = 5) (
	// Watched ports
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [9:0] sampleIn,
	input wire logic [1:0] modeLevel,
	input wire logic       modeConnected,
	input wire logic [9:0] dataOut,
	input wire logic       twosComplement,
	input wire logic       dutyCycleStabilizer
);
	logic [2:0] up;
	logic [1:0] lv;
	// Floating pin reads as ground
	assign lv = modeConnected ? modeLevel : 2'h0;
	always_ff @(posedge clk) up <= !rst_n ? 3'h0 : up + {2'h0, up != 3'h7};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_data_latency: assert property (up == 3'h7 |-> dataOut ==
		($past(sampleIn, LATENCY + 1) ^ {$past(twosComplement), 9'h000})) else $error("word");
	chk_twos_decode: assert property (up != 3'h0 |->
		twosComplement == $past(lv[1])) else $error("coding flag");
	chk_dcs_decode: assert property (up != 3'h0 |->
		dutyCycleStabilizer == ^$past(lv)) else $error("stabilizer flag");
	chk_float_default: assert property (!modeConnected |=>
		!twosComplement && !dutyCycleStabilizer) else $error("floating pin");
	chk_mid_scale: assert property (up == 3'h7 && $past(sampleIn, LATENCY + 1) == 10'h200
		|-> dataOut == {!$past(twosComplement), 9'h000}) else $error("mid scale");
	chk_neg_full: assert property (up == 3'h7 && $past(sampleIn, LATENCY + 1) == 10'h000
		|-> dataOut == {$past(twosComplement), 9'h000}) else $error("neg full");
	chk_mode_hold: assert property (up > 3'h1 && $stable(lv) |=>
		$stable(twosComplement) && $stable(dutyCycleStabilizer)) else $error("mode hold");
	chk_reset_zero: assert property (up == 3'h0 |-> dataOut == 10'h000
		&& !twosComplement && !dutyCycleStabilizer) else $error("reset");
	cover property (twosComplement && dutyCycleStabilizer);
	cover property (up == 3'h7 && !modeConnected);
	cover property (up == 3'h7 && dataOut == 10'h200);
endmodule : adc_output_pipeline_mode_select_properties
bind adc_output_pipeline_mode_select adc_output_pipeline_mode_select_properties
	#(.LATENCY(LATENCY)) chk_i (.*);

/* testbench/adc_output_pipeline_mode_select_tb.sv */
// Random bench with corner words and mode swaps.
// Inputs change on the falling edge; a shadow pipe predicts words.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
	$display("MISMATCH t=%0t %h %h", $time, a, b); end end
module adc_output_pipeline_mode_select_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        modeConnected = 1'b0;
	logic [1:0]  modeLevel = 2'h0;
	logic [9:0]  sampleIn = 10'h000;
	logic [9:0]  dataOut, captured;
	logic        twosComplement, dutyCycleStabilizer;
	logic        relocked;
	logic        relockSeen = 1'b0;
	logic [59:0] pipe;
	logic [3:0]  modes;
	int          n, err_total, samples_checked;
	always #50 clk = ~clk;
	always @(posedge clk)
	begin
		pipe  <= {pipe[49:0], sampleIn};
		modes <= {modes[1:0], modeConnected ? modeLevel : 2'h0};
		n     <= rst_n ? n + 1 : 0;
		if (relocked)
			relockSeen <= 1'b1;
	end
	function logic [9:0] code(logic [9:0] x, logic t);
		return {x[9] ^ t, x[8:0]};
	endfunction : code
	task wrap_up;
		$display("errors %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	adc_output_pipeline_mode_select adc_output_pipeline_mode_select_i (.clk(clk), .rst_n(rst_n),
		.sampleIn(sampleIn), .modeLevel(modeLevel), .modeConnected(modeConnected),
		.dataOut(dataOut), .twosComplement(twosComplement),
		.dutyCycleStabilizer(dutyCycleStabilizer));
	adc_capture_model adc_capture_model_i (.clk(clk), .dataOut(dataOut),
		.stabilizerOn(dutyCycleStabilizer), .captured(captured), .relocked(relocked));
	initial
	begin
		void'($urandom(35));
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		for (int i = 0; i < 400; i++)
		begin
			@(negedge clk);
			if (n >= 1) `CHK({twosComplement, dutyCycleStabilizer}, {modes[1], ^modes[1:0]})
			if (n >= 6) `CHK(captured, code(pipe[59:50], modes[3]))
			`CHK(dataOut, captured)
			// Corners 000, 200, 1ff, 3ff between random words
			sampleIn = i[2] ? 10'($urandom) : {i[0], {9{i[1]}}};
			// Full sweep first, then only stabilizer-enabled levels
			modeLevel = i[8] ? {i[6], ~i[6]} : i[7:6];
			modeConnected = i[8] || (($urandom % 4) != 0);
			rst_n = (i != 200);
		end
		`CHK(relockSeen, 1'b1)
		wrap_up();
	end
endmodule : adc_output_pipeline_mode_select_tb
